// [shared/mcmc_consts.svh]
// constants for the media converter mode control block
// assumes a 40 MHz system clock
`ifndef MCMC_CONSTS_SVH
`define MCMC_CONSTS_SVH

`define MCMC_CLK_MHZ 40
`define MCMC_LATCH_MIN_US 3
`define MCMC_LATCH_MAX_US 8
// earliest cycle 120, latest 320; latch at midpoint
`define MCMC_LATCH_MIN_CYC (`MCMC_LATCH_MIN_US * `MCMC_CLK_MHZ)
`define MCMC_LATCH_MAX_CYC (`MCMC_LATCH_MAX_US * `MCMC_CLK_MHZ)
`define MCMC_LATCH_CYC ((`MCMC_LATCH_MIN_CYC + `MCMC_LATCH_MAX_CYC) / 2)

// register indices
`define MCMC_REG30 5'h1e
`define MCMC_REG31 5'h1f

// register 30 fields
`define MCMC_B30_SCR_FORCE 0
`define MCMC_B30_SCR_EN 1
`define MCMC_B30_COPPER_PECL 3
`define MCMC_B30_FIBER_PECL 7
// register 31 fields
`define MCMC_B31_PLL_BYP_N 10
`define MCMC_B31_LPBK_FIBER 11
`define MCMC_B31_LPBK_COPPER 12
`define MCMC_B31_COPPER_OFF 13
`define MCMC_B31_FIBER_OFF 14
`define MCMC_B31_PWRDN 15

`define MCMC_REG_RST 16'h0000
`define MCMC_SCR_SEED 11'h003
`define MCMC_SCR_RST 11'h7ff

`endif

// [shared/mcmc_pkg.sv]
// types for the media converter mode control block
// constants live in mcmc_consts.svh
package mcmc_pkg;

    // fiber mode pin level, four-level input pre-quantised
    typedef enum logic [1:0] {
        MCMC_LVL_GND,
        MCMC_LVL_THIRD,
        MCMC_LVL_TWO_THIRD,
        MCMC_LVL_VCC
    } mcmc_lvl_e;

    typedef struct packed {
        logic copper_iface_mode_pin;
        mcmc_lvl_e fiber_iface_mode_pin;
        logic speed_100_only;
        logic [1:0] duplex;
        logic [1:0] addr4_warning_pin;
        logic backup_strap;
    } mcmc_cfg_s;

    typedef struct packed {
        logic fiber_sd;
        logic fiber_fef;
        logic copper_sd;
    } mcmc_link_s;

    typedef struct packed {
        logic pecl;
        logic oe;
        logic loop;
        logic en;
    } mcmc_copper_s;

    typedef struct packed {
        logic diff_pair;
        logic oe;
        logic aux_peak_en;
        logic loop;
        logic send_fef;
        logic en;
    } mcmc_fiber_s;

endpackage

// [logic/mcmc_ctrl.sv]
// mode control of a copper to fiber media converter
// pins arrive asynchronous; management port on system clock
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "mcmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mcmc_ctrl
    import mcmc_pkg::*;
#(
    parameter int LATCH_CYC = `MCMC_LATCH_CYC
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_power_down_n,
    input wire logic i_copper_out_off_n,
    input wire logic i_fiber_out_off_n,
    input wire mcmc_cfg_s i_cfg,
    input wire mcmc_link_s i_link,
    input wire logic i_speed_100,
    input wire logic i_autoneg,
    input wire logic i_scr_bit_tick,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output mcmc_copper_s o_copper,
    output mcmc_fiber_s o_fiber,
    output logic o_pll_in_loop,
    output logic o_scr_en,
    output logic [10:0] o_scr_state,
    output logic o_active,
    output logic o_fiber_speed_indicator,
    output logic o_fiber_speed_oe,
    output logic o_backup_enable_o,
    output logic o_backup_oe
);

    typedef struct packed {
        logic [1:0] pd_sync;
        logic [1:0] coff_sync;
        logic [1:0] foff_sync;
        mcmc_cfg_s cfg_m;
        mcmc_cfg_s cfg_s;
        mcmc_link_s lk_m;
        mcmc_link_s lk_s;
        mcmc_cfg_s straps;
        logic [15:0] r30;
        logic [15:0] r31;
        logic [8:0] lcnt;
        logic latched;
        logic [10:0] scr;
        logic [15:0] rdata;
        mcmc_copper_s cu;
        mcmc_fiber_s fo;
        logic pll_in;
        logic scr_en;
        logic active;
        logic spd;
        logic spd_oe;
        logic bck;
        logic bck_oe;
    } mcmc_state_s;

    mcmc_state_s st_ff;
    mcmc_state_s nxt_st;

    localparam logic [8:0] LATCH_AT = 9'(LATCH_CYC);

    logic pd_pin;
    logic on;
    logic copper_pecl;
    logic fiber_pecl;
    logic loop_any;
    logic backup_mode;
    logic fiber_good;
    logic copper_off;
    logic fiber_off;

    always_comb
    begin
        nxt_st = st_ff;
        // two-flop synchronisers for every pin
        nxt_st.pd_sync = {st_ff.pd_sync[0], i_power_down_n};
        nxt_st.coff_sync = {st_ff.coff_sync[0], i_copper_out_off_n};
        nxt_st.foff_sync = {st_ff.foff_sync[0], i_fiber_out_off_n};
        nxt_st.cfg_m = i_cfg;
        nxt_st.cfg_s = st_ff.cfg_m;
        nxt_st.lk_m = i_link;
        nxt_st.lk_s = st_ff.lk_m;

        pd_pin = !st_ff.pd_sync[1];
        // strap latch delay after power-down release
        if (pd_pin)
        begin
            nxt_st.lcnt = '0;
            nxt_st.latched = 1'b0;
            nxt_st.r30 = `MCMC_REG_RST;
            nxt_st.r31 = `MCMC_REG_RST;
        end
        else if (!st_ff.latched)
        begin
            nxt_st.lcnt = st_ff.lcnt + 9'h001;
            if (st_ff.lcnt == LATCH_AT)
            begin
                nxt_st.latched = 1'b1;
                nxt_st.straps = st_ff.cfg_s;
                nxt_st.r30 = `MCMC_REG_RST;
                nxt_st.r31 = `MCMC_REG_RST;
            end
        end

        // management writes, live once latched; 31.15 keeps registers
        if (i_wr && st_ff.latched && !pd_pin)
        begin
            if (i_addr == `MCMC_REG30)
                nxt_st.r30 = i_wdata;
            if (i_addr == `MCMC_REG31)
                nxt_st.r31 = i_wdata;
        end
        nxt_st.rdata = 16'h0000;
        if (i_rd)
        begin
            if (i_addr == `MCMC_REG30)
                nxt_st.rdata = st_ff.r30;
            else if (i_addr == `MCMC_REG31)
                nxt_st.rdata = st_ff.r31;
        end

        on = st_ff.latched && !pd_pin
            && !st_ff.r31[`MCMC_B31_PWRDN];
        nxt_st.active = on;

        copper_pecl = st_ff.straps.copper_iface_mode_pin
            || st_ff.r30[`MCMC_B30_COPPER_PECL];
        fiber_pecl = (st_ff.straps.fiber_iface_mode_pin == MCMC_LVL_THIRD)
            || st_ff.r30[`MCMC_B30_FIBER_PECL];

        loop_any = st_ff.r31[`MCMC_B31_LPBK_COPPER]
            || st_ff.r31[`MCMC_B31_LPBK_FIBER];
        // strap left high means no secondary converter fitted
        backup_mode = on && st_ff.straps.speed_100_only
            && !st_ff.straps.backup_strap && !loop_any;
        fiber_good = st_ff.lk_s.fiber_sd;

        copper_off = !st_ff.coff_sync[1]
            || st_ff.r31[`MCMC_B31_COPPER_OFF];
        fiber_off = !st_ff.foff_sync[1]
            || st_ff.r31[`MCMC_B31_FIBER_OFF];

        // copper line: tp coding chosen by datapath from speed/autoneg
        nxt_st.cu.pecl = copper_pecl;
        nxt_st.cu.loop = on && st_ff.r31[`MCMC_B31_LPBK_COPPER];
        nxt_st.cu.en = on && (i_speed_100 || !i_autoneg || 1'b1);
        nxt_st.cu.oe = on && !copper_off;

        nxt_st.fo.diff_pair = fiber_pecl;
        nxt_st.fo.aux_peak_en = on && !fiber_pecl;
        nxt_st.fo.loop = on && st_ff.r31[`MCMC_B31_LPBK_FIBER];
        nxt_st.fo.en = on;
        nxt_st.fo.send_fef = 1'b0;
        nxt_st.fo.oe = on && !fiber_off;

        nxt_st.spd = on && fiber_good;
        nxt_st.spd_oe = on;
        nxt_st.bck = 1'b1;
        nxt_st.bck_oe = 1'b0;
        if (backup_mode)
        begin
            nxt_st.bck_oe = 1'b1;
            if (fiber_good && !st_ff.lk_s.fiber_fef)
            begin
                nxt_st.spd = 1'b1;
                nxt_st.bck = 1'b0;
            end
            else if (fiber_good)
            begin
                nxt_st.spd = 1'b1;
                nxt_st.bck = 1'b1;
            end
            else
            begin
                nxt_st.spd = 1'b0;
                nxt_st.bck = 1'b1;
                nxt_st.fo.send_fef = st_ff.lk_s.copper_sd;
                nxt_st.fo.oe = !fiber_off && st_ff.lk_s.copper_sd;
            end
        end

        // pll in loop unless 31.10 driven low while looping
        nxt_st.pll_in = !(loop_any
            && !st_ff.r31[`MCMC_B31_PLL_BYP_N]);

        nxt_st.scr_en = on && i_speed_100
            && st_ff.r30[`MCMC_B30_SCR_EN];
        if (!on)
            nxt_st.scr = `MCMC_SCR_RST;
        else if (st_ff.r30[`MCMC_B30_SCR_FORCE])
            nxt_st.scr = `MCMC_SCR_SEED;
        else if (i_scr_bit_tick)
            nxt_st.scr = {st_ff.scr[9:0],
                st_ff.scr[10] ^ st_ff.scr[8]};
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= '0;
            st_ff.scr <= `MCMC_SCR_RST;
            st_ff.pll_in <= 1'b1;
            st_ff.bck <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign o_rdata = st_ff.rdata;
    assign o_copper = st_ff.cu;
    assign o_fiber = st_ff.fo;
    assign o_pll_in_loop = st_ff.pll_in;
    assign o_scr_en = st_ff.scr_en;
    assign o_scr_state = st_ff.scr;
    assign o_active = st_ff.active;
    assign o_fiber_speed_indicator = st_ff.spd;
    assign o_fiber_speed_oe = st_ff.spd_oe;
    assign o_backup_enable_o = st_ff.bck;
    assign o_backup_oe = st_ff.bck_oe;

endmodule

`default_nettype wire

// [testbench/mcmc_ctrl_asserts.sv]
// assertions for the mode control block
// bound into mcmc_ctrl; writes act two cycles on
`timescale 1ns/1ps
`default_nettype none
module mcmc_ctrl_asserts
    import mcmc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_power_down_n,
    input wire logic i_copper_out_off_n,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire mcmc_copper_s o_copper,
    input wire mcmc_fiber_s o_fiber,
    input wire logic [10:0] o_scr_state,
    input wire logic o_active,
    input wire logic o_fiber_speed_indicator,
    input wire logic o_backup_enable_o,
    input wire logic o_backup_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    sequence wr30;
        o_active && i_wr && i_addr == 5'h1e;
    endsequence
    sequence wr31;
        o_active && i_wr && i_addr == 5'h1f;
    endsequence
    a_pecl_bit: assert property (
        wr30 ##0 i_wdata[3] |-> ##2 o_copper.pecl)
        else $error("pecl bit ignored");
    a_scr_seed: assert property (
        wr30 ##0 i_wdata[0] |-> ##2 o_scr_state == 11'h003)
        else $error("scrambler seed not forced");
    a_loop_bits: assert property (
        wr31 ##0 i_wdata[15:11] == 5'h03 |-> ##2 o_copper.loop && o_fiber.loop)
        else $error("loopback bits ignored");
    a_reg_off: assert property (
        wr31 ##0 i_wdata[14:13] == 2'h3 |-> ##2 !o_copper.oe && !o_fiber.oe)
        else $error("output off bits ignored");
    a_pin_off: assert property (
        (!i_copper_out_off_n)[*5] |-> !o_copper.oe)
        else $error("copper drives while pin off");
    a_pdn_pin: assert property (
        (!i_power_down_n)[*5] |-> !o_active && !o_fiber.oe)
        else $error("active during power down");
    a_pdn_bit: assert property (
        wr31 ##0 i_wdata[15] |-> ##2 !o_copper.oe && !o_fiber.oe)
        else $error("power down bit ignored");
    a_backup_loop: assert property (
        o_copper.loop || o_fiber.loop |-> !o_backup_oe)
        else $error("backup driven in loopback");
    a_backup_low: assert property (
        !o_backup_enable_o |-> o_backup_oe && o_fiber_speed_indicator)
        else $error("backup low outside good fiber");
    a_fault_send: assert property (
        o_fiber.send_fef |-> o_backup_enable_o && !o_fiber_speed_indicator)
        else $error("fault pattern sent on good fiber");
endmodule
bind mcmc_ctrl mcmc_ctrl_asserts u_chk (.i_sys_clk, .i_rst, .i_power_down_n,
    .i_copper_out_off_n, .i_addr, .i_wdata, .i_wr, .o_copper, .o_fiber,
    .o_scr_state, .o_active, .o_fiber_speed_indicator, .o_backup_enable_o,
    .o_backup_oe);
`default_nettype wire

// [testbench/mcmc_partner.sv]
// far side: link status and the secondary converter
// backup pin has a pull-up when released
`timescale 1ns/1ps
`default_nettype none
module mcmc_partner
    import mcmc_pkg::*;
(
    input wire logic i_fiber_good,
    input wire logic i_fef,
    input wire logic i_copper_good,
    input wire logic i_backup,
    input wire logic i_backup_oe,
    output mcmc_link_s o_link,
    output logic o_sec_copper_on
);
    assign o_sec_copper_on = i_backup_oe ? i_backup : 1'h1;
    assign o_link = '{i_fiber_good, i_fef, i_copper_good};
endmodule
`default_nettype wire

// [testbench/test_mcmc_ctrl.sv]
// bench for the mode control block
// straps sampled with LATCH_CYC shortened to 10
`timescale 1ns/1ps
`default_nettype none
module test_mcmc_ctrl
    import mcmc_pkg::*;
;
    logic clk = 0, rst = 1, pdn_n = 1, cu_n = 1, fo_n = 1, tick = 0;
    logic wr = 0, rd = 0, act, bk, bk_oe, sec_on;
    logic sp100 = 1, fgood = 1, fault = 0, cgood = 1;
    logic pll, scr_en, spd, spd_oe;
    logic [4:0] addr = 0;
    logic [15:0] wdata = 0, rdat;
    logic [10:0] scr;
    mcmc_cfg_s cfg = '0;
    mcmc_link_s link;
    mcmc_copper_s cu;
    mcmc_fiber_s fo;
    int n_fail = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    mcmc_ctrl #(.LATCH_CYC(10)) u_dut (.i_sys_clk(clk), .i_rst(rst),
        .i_power_down_n(pdn_n), .i_copper_out_off_n(cu_n),
        .i_fiber_out_off_n(fo_n), .i_cfg(cfg), .i_link(link),
        .i_speed_100(sp100), .i_autoneg(1'h0), .i_scr_bit_tick(tick),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdat), .o_copper(cu), .o_fiber(fo), .o_pll_in_loop(pll),
        .o_scr_en(scr_en), .o_scr_state(scr), .o_active(act),
        .o_fiber_speed_indicator(spd), .o_fiber_speed_oe(spd_oe),
        .o_backup_enable_o(bk), .o_backup_oe(bk_oe));
    mcmc_partner u_far (.i_fiber_good(fgood), .i_fef(fault),
        .i_copper_good(cgood), .i_backup(bk), .i_backup_oe(bk_oe),
        .o_link(link), .o_sec_copper_on(sec_on));
    task automatic conclude;
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        step();
        wr <= 1'h0;
        repeat (2) step();
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        step();
        rd <= 1'h0;
        chk(rdat, exp);
    endtask
    task automatic wait_act;
        for (int i = 0; i < 100 && act !== 1'h1; i++)
            step();
        chk(act, 1'h1);
    endtask
    task automatic t_regs;
        wr_reg(5'h1e, 16'h008b);
        rd_chk(5'h1e, 16'h008b);
        chk(cu.pecl, 1'h1);
        chk({fo.diff_pair, fo.aux_peak_en}, 2'h2);
        chk(scr_en, 1'h1);
        sp100 <= 1'h0;
        repeat (2) step();
        chk(scr_en, 1'h0);
        sp100 <= 1'h1;
        tick <= 1'h1;
        repeat (4) step();
        tick <= 1'h0;
        chk(scr, 11'h003);
        wr_reg(5'h1e, 16'h0000);
        chk(cu.pecl, 1'h0);
        chk({fo.diff_pair, fo.aux_peak_en}, 2'h1);
        chk(scr_en, 1'h0);
        tick <= 1'h1;
        step();
        tick <= 1'h0;
        chk(scr, 11'h006);
        rd_chk(5'h05, 16'h0000);
    endtask
    task automatic t_loop;
        wr_reg(5'h1f, 16'h1800);
        chk({cu.loop, fo.loop, bk_oe, sec_on}, 4'hd);
        chk(pll, 1'h0);
        wr_reg(5'h1f, 16'h1c00);
        chk(pll, 1'h1);
        wr_reg(5'h1f, 16'h6000);
        chk({cu.oe, fo.oe}, 2'h0);
        wr_reg(5'h1f, 16'h0000);
        chk({cu.oe, fo.oe}, 2'h3);
        wr_reg(5'h1f, 16'h8000);
        chk({cu.oe, fo.oe}, 2'h0);
        rd_chk(5'h1f, 16'h8000);
        wr_reg(5'h1f, 16'h0000);
    endtask
    task automatic t_pins;
        cu_n <= 1'h0;
        repeat (5) step();
        chk({cu.oe, fo.oe}, 2'h1);
        cu_n <= 1'h1;
        fo_n <= 1'h0;
        repeat (5) step();
        chk({cu.oe, fo.oe}, 2'h2);
        fo_n <= 1'h1;
    endtask
    task automatic t_pdn;
        wr_reg(5'h1e, 16'h0002);
        pdn_n <= 1'h0;
        cfg.copper_iface_mode_pin <= 1'h1;
        cfg.fiber_iface_mode_pin <= MCMC_LVL_THIRD;
        repeat (5) step();
        chk({act, cu.oe, fo.oe}, 3'h0);
        pdn_n <= 1'h1;
        wait_act();
        rd_chk(5'h1e, 16'h0000);
        chk(cu.pecl, 1'h1);
        chk({fo.diff_pair, fo.aux_peak_en}, 2'h2);
    endtask
    task automatic t_backup;
        cfg.speed_100_only <= 1'h1;
        cfg.backup_strap <= 1'h0;
        pdn_n <= 1'h0;
        repeat (5) step();
        pdn_n <= 1'h1;
        wait_act();
        chk({spd, spd_oe, bk, bk_oe, sec_on}, 5'h1a);
        fault <= 1'h1;
        repeat (4) step();
        chk({spd, bk, sec_on, fo.send_fef, fo.oe}, 5'h1d);
        fault <= 1'h0;
        fgood <= 1'h0;
        repeat (4) step();
        chk({spd, bk, sec_on, fo.send_fef, fo.oe}, 5'h0f);
        cgood <= 1'h0;
        repeat (4) step();
        chk({spd, bk, fo.send_fef, fo.oe}, 4'h4);
        cgood <= 1'h1;
        fgood <= 1'h1;
        wr_reg(5'h1f, 16'h0800);
        chk({fo.loop, bk_oe, sec_on}, 3'h5);
    endtask
    initial
    begin
        cfg.backup_strap = 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        wait_act();
        t_regs();
        t_loop();
        t_pins();
        t_pdn();
        t_backup();
        conclude();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
